// [inc/sdsm_pkg.sv]
package sdsm_pkg;

   // Power-stage states, one-hot
   typedef enum logic [5:0] {
      ST_INIT = 6'h01,
      ST_DIS = 6'h02,
      ST_READY = 6'h04,
      ST_SWON = 6'h08,
      ST_OPEN = 6'h10,
      ST_FAULT = 6'h20
   } sdsm_state_t;

   // Decoded host commands; disable-operation shares the switch-on code
   typedef enum logic [2:0] {
      CMD_SHUTDOWN = 3'h1,
      CMD_SWITCH_ON = 3'h2,
      CMD_DISABLE_VOLT = 3'h3,
      CMD_ENABLE_OP = 3'h4,
      CMD_CLEAR_FAULT = 3'h5
   } sdsm_cmd_t;

   // Reference shaper state
   typedef struct packed {
      logic signed [15:0] ramp;
      logic signed [15:0] lpf;
   } sdsm_filt_t;

   // Supervisor state
   typedef struct packed {
      sdsm_state_t state;
      logic [15:0] cmd_word;
      logic [7:0] mode_sel;
      logic [7:0] mode_act;
      logic [31:0] pos_set;
      logic [31:0] vel_set;
      logic [15:0] cur_set;
      logic [31:0] pos_ref;
      logic [15:0] fault_reg;
      logic [15:0] state_word;
      logic [31:0] rdata;
      logic ack;
      logic err;
      logic pwm;
      logic power;
      logic drive;
   } sdsm_core_t;

endpackage : sdsm_pkg

// [inc/sdsm_regs.svh]
`ifndef SDSM_REGS_SVH
`define SDSM_REGS_SVH

// Object indices on the object access port
`define SDSM_IDX_FAULT_CAUSE 16'h603F
`define SDSM_IDX_CMD_WORD 16'h6040
`define SDSM_IDX_STATE_WORD 16'h6041
`define SDSM_IDX_MODE_SEL 16'h6060
`define SDSM_IDX_MODE_ACT 16'h6061
`define SDSM_IDX_POS_DEMAND 16'h6062
`define SDSM_IDX_POS_MEAS 16'h6064
`define SDSM_IDX_VEL_DEMAND 16'h606B
`define SDSM_IDX_VEL_MEAS 16'h606C
`define SDSM_IDX_CUR_SET 16'h6071
`define SDSM_IDX_CUR_DEMAND 16'h6074
`define SDSM_IDX_RATED_CUR 16'h6075
`define SDSM_IDX_CUR_MEAS 16'h6077
`define SDSM_IDX_VBUS 16'h6079
`define SDSM_IDX_POS_SET 16'h607A
`define SDSM_IDX_SPEED_LIM 16'h6080
`define SDSM_IDX_VEL_SET 16'h60FF

// Command word bit positions
`define SDSM_CMD_ARM_BIT 0
`define SDSM_CMD_POWER_BIT 1
`define SDSM_CMD_RUN_BIT 3
`define SDSM_CMD_CLEAR_BIT 7

// State word bit positions
`define SDSM_ST_RDY_BIT 0
`define SDSM_ST_SWON_BIT 1
`define SDSM_ST_OPEN_BIT 2
`define SDSM_ST_FAULT_BIT 3
`define SDSM_ST_VOLT_BIT 4
`define SDSM_ST_DIS_BIT 6
`define SDSM_ST_CAL_BIT 8

// Fault cause bit positions
`define SDSM_FAULT_ENC_BIT 9

// Operating mode codes
`define SDSM_MODE_FREE 8'h00
`define SDSM_MODE_POS 8'h01
`define SDSM_MODE_VEL 8'h03
`define SDSM_MODE_TORQUE 8'h04
`define SDSM_MODE_SYNC_POS 8'h08

// Reset values
`define SDSM_CMD_WORD_RST 16'h0000
`define SDSM_STATE_WORD_RST 16'h0010
`define SDSM_MODE_RST 8'h00
`define SDSM_SET16_RST 16'h0000
`define SDSM_SET32_RST 32'h00000000

// Current reference shaping: slew per cycle and low-pass shift
`define SDSM_CUR_STEP 17'h00040
`define SDSM_CUR_SHIFT 4

`endif

// [logic/sdsm_cmd_decode.sv]
`timescale 1ns/10ps
`default_nettype none
`include "sdsm_regs.svh"

module sdsm_cmd_decode
   import sdsm_pkg::*;
(
   // Raw command word
   input wire logic [15:0] cmd_word_in,
   // Decoded command
   output sdsm_cmd_t cmd_out
);

   // Clear-fault first, then the voltage and arm bits; bits outside 7,3,1,0 are ignored
   always_comb begin
      if (cmd_word_in[`SDSM_CMD_CLEAR_BIT]) begin // R26
         cmd_out = CMD_CLEAR_FAULT; // R13
      end else if (!cmd_word_in[`SDSM_CMD_POWER_BIT]) begin
         cmd_out = CMD_DISABLE_VOLT; // R13
      end else if (!cmd_word_in[`SDSM_CMD_ARM_BIT]) begin
         cmd_out = CMD_SHUTDOWN; // R13
      end else if (cmd_word_in[`SDSM_CMD_RUN_BIT]) begin
         cmd_out = CMD_ENABLE_OP; // R13
      end else begin
         cmd_out = CMD_SWITCH_ON; // R1
      end
   end

endmodule : sdsm_cmd_decode
`default_nettype wire

// [logic/sdsm_ref_filter.sv]
`timescale 1ns/10ps
`default_nettype none
`include "sdsm_regs.svh"

module sdsm_ref_filter
   import sdsm_pkg::*;
#(
   parameter logic signed [16:0] STEP = `SDSM_CUR_STEP,
   parameter int SHIFT = `SDSM_CUR_SHIFT
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic resetn_in,
   // Raw target and shaped reference
   input wire logic signed [15:0] target_in,
   output logic signed [15:0] ref_out
);

   sdsm_filt_t q;
   sdsm_filt_t d;
   logic signed [16:0] diff;
   logic signed [16:0] err;
   logic signed [16:0] err_sh;

   // Slew limit first, then a first-order low-pass on the slewed value
   always_comb begin
      d = q;
      diff = {target_in[15], target_in} - {q.ramp[15], q.ramp};
      if (diff > STEP) begin
         d.ramp = q.ramp + STEP[15:0]; // R20
      end else if (diff < -STEP) begin
         d.ramp = q.ramp - STEP[15:0]; // R20
      end else begin
         d.ramp = target_in;
      end
      err = {q.ramp[15], q.ramp} - {q.lpf[15], q.lpf};
      err_sh = err >>> SHIFT;
      d.lpf = q.lpf + err_sh[15:0]; // R20
   end

   // State register
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign ref_out = q.lpf;

endmodule : sdsm_ref_filter
`default_nettype wire

// [logic/sdsm_supervisor.sv]
// What this block does
// R1 - Command word: bit0 arm, bit1 power allow, bit3 run, bit7 clear fault.
// R2 - State word bit 8 is set while offset calibration runs.
// R3 - During offset calibration PWM stays on but no power reaches windings.
// R4 - Voltage-enabled bit of the state word always reads one.
// R5 - State code on bits 6,3,2,1,0 per state table.
// R6 - Reset enters initializing; successful init moves to disabled.
// R7 - Shutdown goes to ready from disabled, switched on or running.
// R8 - Switch-on in ready goes to switched on, PWM still off.
// R9 - Enable-operation in switched on goes to running with PWM active.
// R10 - Enable-operation in ready passes switched on then running.
// R11 - Disable-operation in running returns to switched on, PWM off.
// R12 - Disable-voltage goes to disabled from ready, switched on, running.
// R13 - Commands decode from bits 7,3,1,0 per command table.
// R14 - Any drive fault forces fault state from all states, stage off.
// R15 - Fault entry cause is recorded in the fault cause word.
// R16 - Clear-fault in fault state goes to disabled.
// R17 - Mode select accepts 0x00,0x01,0x03,0x04,0x08; copy shows active mode.
// R18 - In synchronous position mode reference updates only on SYNC.
// R19 - Current values are signed 16-bit fractions, 32768 is full rated.
// R20 - Demand values are slew-limited, low-pass filtered targets.
// R21 - Position in float radians, velocity in float RPM.
// R22 - Bus voltage is unsigned 16-bit millivolts.
// R23 - Host sends shutdown, waits ready, sends enable, waits running.
// R24 - Fault cause word is read-only 16 bits, bit 9 encoder fault.
// R25 - Commands with no transition from the current state are ignored.
// R26 - Clear-fault beats other bits; state evaluated once per cycle.
`timescale 1ns/10ps
`default_nettype none
`include "sdsm_regs.svh"

module sdsm_supervisor
   import sdsm_pkg::*;
#(
   parameter logic [31:0] RATED_CURRENT = 32'h00000000,
   parameter logic [31:0] SPEED_LIMIT = 32'h00000000
) (
   // Clock and reset
   input wire logic SYS_CLK_IN,
   input wire logic RESETN_IN,
   // Object access port
   input wire logic [15:0] OBJ_INDEX_IN,
   input wire logic OBJ_WR_IN,
   input wire logic OBJ_RD_IN,
   input wire logic [31:0] OBJ_WDATA_IN,
   output logic [31:0] OBJ_RDATA_OUT,
   output logic OBJ_ACK_OUT,
   output logic OBJ_ERR_OUT,
   // Drive events
   input wire logic INIT_DONE_IN,
   input wire logic [15:0] FAULT_CAUSE_IN,
   input wire logic ADC_CAL_IN,
   input wire logic SYNC_IN,
   // Measurements and loop demands
   input wire logic [31:0] POS_MEAS_IN,
   input wire logic [31:0] VEL_MEAS_IN,
   input wire logic [31:0] POS_DEMAND_IN,
   input wire logic [31:0] VEL_DEMAND_IN,
   input wire logic [15:0] CUR_MEAS_IN,
   input wire logic [15:0] VBUS_MV_IN,
   // Power stage and references
   output logic [15:0] STATE_WORD_OUT,
   output logic [7:0] MODE_ACTIVE_OUT,
   output logic DRIVE_EN_OUT,
   output logic PWM_EN_OUT,
   output logic POWER_EN_OUT,
   output logic [31:0] POS_REF_OUT,
   output logic [31:0] VEL_REF_OUT,
   output logic signed [15:0] CUR_REF_OUT
);

   sdsm_core_t q;
   sdsm_core_t d;
   sdsm_cmd_t cmd;
   logic fault_any;
   logic mode_ok;
   logic signed [15:0] cur_demand;

   // Command decode of the stored word
   sdsm_cmd_decode u_decode (
      .cmd_word_in(q.cmd_word),
      .cmd_out(cmd)
   );

   // Current reference shaping; the loop sees the shaped value, never the raw setpoint
   sdsm_ref_filter #(
      .STEP(`SDSM_CUR_STEP),
      .SHIFT(`SDSM_CUR_SHIFT)
   ) u_cur_filter (
      .clk_in(SYS_CLK_IN),
      .resetn_in(RESETN_IN),
      .target_in(q.cur_set),
      .ref_out(cur_demand)
   );

   assign fault_any = |FAULT_CAUSE_IN;

   // Only the listed mode codes are taken; anything else is refused
   always_comb begin
      case (OBJ_WDATA_IN[7:0])
         `SDSM_MODE_FREE, `SDSM_MODE_POS, `SDSM_MODE_VEL,
         `SDSM_MODE_TORQUE, `SDSM_MODE_SYNC_POS: mode_ok = 1'b1; // R17
         default: mode_ok = 1'b0;
      endcase
   end

   // State word from a state; calibration and voltage bits are added on top
   function automatic logic [15:0] state_code(input sdsm_state_t s, input logic cal);
      logic [15:0] w;
      w = 16'h0000;
      case (s)
         ST_INIT: w = 16'h0000; // R5
         ST_DIS: w[`SDSM_ST_DIS_BIT] = 1'b1; // R5
         ST_READY: w[`SDSM_ST_RDY_BIT] = 1'b1; // R5
         ST_SWON: begin
            w[`SDSM_ST_RDY_BIT] = 1'b1;
            w[`SDSM_ST_SWON_BIT] = 1'b1; // R5
         end
         ST_OPEN: begin
            w[`SDSM_ST_RDY_BIT] = 1'b1;
            w[`SDSM_ST_SWON_BIT] = 1'b1;
            w[`SDSM_ST_OPEN_BIT] = 1'b1; // R5
         end
         ST_FAULT: w[`SDSM_ST_FAULT_BIT] = 1'b1; // R5
         default: w = 16'h0000;
      endcase
      // Drive voltage cannot be removed, so this bit never drops
      w[`SDSM_ST_VOLT_BIT] = 1'b1; // R4
      w[`SDSM_ST_CAL_BIT] = cal; // R2
      return w;
   endfunction : state_code

   // Next state: faults first, then one command step per cycle
   always_comb begin
      d = q;
      d.ack = 1'b0;
      d.err = 1'b0;
      if (fault_any && q.state != ST_FAULT) begin
         d.state = ST_FAULT; // R14
         d.fault_reg = FAULT_CAUSE_IN; // R15
      end else begin
         case (q.state)
            ST_INIT: begin
               if (INIT_DONE_IN) begin
                  d.state = ST_DIS; // R6
               end
            end
            ST_DIS: begin
               if (cmd == CMD_SHUTDOWN) begin
                  d.state = ST_READY; // R7
               end
            end
            ST_READY: begin
               // Enable-operation steps through switched on on its way up
               if (cmd == CMD_SWITCH_ON || cmd == CMD_ENABLE_OP) begin
                  d.state = ST_SWON; // R8 R10
               end else if (cmd == CMD_DISABLE_VOLT) begin
                  d.state = ST_DIS; // R12
               end
            end
            ST_SWON: begin
               if (cmd == CMD_ENABLE_OP) begin
                  d.state = ST_OPEN; // R9 R10
               end else if (cmd == CMD_SHUTDOWN) begin
                  d.state = ST_READY; // R7
               end else if (cmd == CMD_DISABLE_VOLT) begin
                  d.state = ST_DIS; // R12
               end
            end
            ST_OPEN: begin
               // Disable-operation carries the same code as switch-on
               if (cmd == CMD_SWITCH_ON) begin
                  d.state = ST_SWON; // R11
               end else if (cmd == CMD_SHUTDOWN) begin
                  d.state = ST_READY; // R7
               end else if (cmd == CMD_DISABLE_VOLT) begin
                  d.state = ST_DIS; // R12
               end
            end
            ST_FAULT: begin
               // A fault still present keeps the state; clearing cannot mask it
               d.fault_reg = q.fault_reg | FAULT_CAUSE_IN;
               if (cmd == CMD_CLEAR_FAULT && !fault_any) begin
                  d.state = ST_DIS; // R16
                  d.fault_reg = 16'h0000;
               end
            end
            default: d.state = ST_INIT;
         endcase
         // Any other command leaves the state as it is R25
      end

      // Object writes; read-only and unknown indices answer with an error
      if (OBJ_WR_IN) begin
         d.ack = 1'b1;
         case (OBJ_INDEX_IN)
            `SDSM_IDX_CMD_WORD: d.cmd_word = OBJ_WDATA_IN[15:0]; // R1
            `SDSM_IDX_MODE_SEL: begin
               if (mode_ok) begin
                  d.mode_sel = OBJ_WDATA_IN[7:0]; // R17
               end else begin
                  d.err = 1'b1;
               end
            end
            `SDSM_IDX_CUR_SET: d.cur_set = OBJ_WDATA_IN[15:0]; // R19
            `SDSM_IDX_POS_SET: d.pos_set = OBJ_WDATA_IN; // R21
            `SDSM_IDX_VEL_SET: d.vel_set = OBJ_WDATA_IN; // R21
            default: d.err = 1'b1;
         endcase
      end else if (OBJ_RD_IN) begin
         d.ack = 1'b1;
         d.rdata = 32'h00000000;
         case (OBJ_INDEX_IN)
            `SDSM_IDX_FAULT_CAUSE: d.rdata[15:0] = q.fault_reg; // R24
            `SDSM_IDX_CMD_WORD: d.rdata[15:0] = q.cmd_word;
            `SDSM_IDX_STATE_WORD: d.rdata[15:0] = q.state_word;
            `SDSM_IDX_MODE_SEL: d.rdata[7:0] = q.mode_sel;
            `SDSM_IDX_MODE_ACT: d.rdata[7:0] = q.mode_act; // R17
            `SDSM_IDX_POS_DEMAND: d.rdata = POS_DEMAND_IN; // R20 R21
            `SDSM_IDX_POS_MEAS: d.rdata = POS_MEAS_IN; // R21
            `SDSM_IDX_VEL_DEMAND: d.rdata = VEL_DEMAND_IN; // R20 R21
            `SDSM_IDX_VEL_MEAS: d.rdata = VEL_MEAS_IN; // R21
            `SDSM_IDX_CUR_SET: d.rdata = {{16{q.cur_set[15]}}, q.cur_set}; // R19
            `SDSM_IDX_CUR_DEMAND: d.rdata = {{16{cur_demand[15]}}, cur_demand}; // R20
            `SDSM_IDX_RATED_CUR: d.rdata = RATED_CURRENT;
            `SDSM_IDX_CUR_MEAS: d.rdata = {{16{CUR_MEAS_IN[15]}}, CUR_MEAS_IN}; // R19
            `SDSM_IDX_VBUS: d.rdata[15:0] = VBUS_MV_IN; // R22
            `SDSM_IDX_POS_SET: d.rdata = q.pos_set;
            `SDSM_IDX_SPEED_LIM: d.rdata = SPEED_LIMIT;
            `SDSM_IDX_VEL_SET: d.rdata = q.vel_set;
            default: d.err = 1'b1;
         endcase
      end

      // The active mode follows the selection one cycle later
      d.mode_act = q.mode_sel; // R17

      // Position reference: held for SYNC in synchronous mode, else follows the setpoint
      if (q.mode_act == `SDSM_MODE_SYNC_POS) begin
         if (SYNC_IN) begin
            d.pos_ref = q.pos_set; // R18
         end
      end else begin
         d.pos_ref = q.pos_set;
      end

      // Stage controls from the next state so they line up with the state word
      d.state_word = state_code(d.state, ADC_CAL_IN);
      d.drive = (d.state == ST_SWON) || (d.state == ST_OPEN); // R8
      // Calibration needs switching to measure offsets, but a fault overrides it
      d.pwm = (d.state == ST_OPEN) || (ADC_CAL_IN && d.state != ST_FAULT); // R3 R9 R14
      d.power = (d.state == ST_OPEN) && !ADC_CAL_IN; // R3 R11 R14
   end

   // State register
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RESETN_IN) begin
         q <= '0;
         q.state <= ST_INIT; // R6
         q.cmd_word <= `SDSM_CMD_WORD_RST;
         q.mode_sel <= `SDSM_MODE_RST;
         q.mode_act <= `SDSM_MODE_RST;
         q.cur_set <= `SDSM_SET16_RST;
         q.pos_set <= `SDSM_SET32_RST;
         q.vel_set <= `SDSM_SET32_RST;
         q.state_word <= `SDSM_STATE_WORD_RST;
      end else begin
         q <= d;
      end
   end

   // Outputs straight from the register
   assign OBJ_RDATA_OUT = q.rdata;
   assign OBJ_ACK_OUT = q.ack;
   assign OBJ_ERR_OUT = q.err;
   assign STATE_WORD_OUT = q.state_word;
   assign MODE_ACTIVE_OUT = q.mode_act;
   assign DRIVE_EN_OUT = q.drive;
   assign PWM_EN_OUT = q.pwm;
   assign POWER_EN_OUT = q.power;
   assign POS_REF_OUT = q.pos_ref;
   assign VEL_REF_OUT = q.vel_set;
   assign CUR_REF_OUT = cur_demand;

   // Checks
   default clocking cb @(posedge SYS_CLK_IN);
   endclocking
   default disable iff (!RESETN_IN);

   sequence s_ready_enable;
      q.state == ST_READY && cmd == CMD_ENABLE_OP && !fault_any;
   endsequence

   sequence s_still_enable;
      cmd == CMD_ENABLE_OP && !fault_any;
   endsequence

   a_init_leave: assert property ( // R6
      q.state == ST_INIT && INIT_DONE_IN && !fault_any |=> q.state == ST_DIS)
      else $error("init done did not reach disabled");
   a_shutdown_ready: assert property ( // R7
      (q.state inside {ST_DIS, ST_SWON, ST_OPEN}) && cmd == CMD_SHUTDOWN && !fault_any
      |=> q.state == ST_READY)
      else $error("shutdown did not reach ready");
   a_switch_on: assert property ( // R8
      q.state == ST_READY && cmd == CMD_SWITCH_ON && !fault_any && !ADC_CAL_IN
      |=> q.state == ST_SWON && DRIVE_EN_OUT && !PWM_EN_OUT)
      else $error("switch on step wrong");
   a_ready_run: assert property ( // R10
      s_ready_enable ##1 s_still_enable |=> q.state == ST_OPEN && q.state_word[2:0] == 3'h7)
      else $error("ready to running did not pass in two steps");
   a_disable_op: assert property ( // R11
      q.state == ST_OPEN && cmd == CMD_SWITCH_ON && !fault_any
      |=> q.state == ST_SWON && !POWER_EN_OUT)
      else $error("disable operation failed");
   a_disable_volt: assert property ( // R12
      (q.state inside {ST_READY, ST_SWON, ST_OPEN}) && cmd == CMD_DISABLE_VOLT && !fault_any
      |=> q.state == ST_DIS && STATE_WORD_OUT[6])
      else $error("disable voltage failed");
   a_fault_entry: assert property ( // R14
      fault_any |=> q.state == ST_FAULT && !POWER_EN_OUT && !DRIVE_EN_OUT)
      else $error("fault did not stop the stage");
   a_fault_record: assert property ( // R15
      fault_any && q.state != ST_FAULT |=> q.fault_reg == $past(FAULT_CAUSE_IN))
      else $error("fault cause not recorded");
   a_fault_clear: assert property ( // R16
      q.state == ST_FAULT && cmd == CMD_CLEAR_FAULT && !fault_any
      |=> q.state == ST_DIS ##1 q.state != ST_FAULT || $past(fault_any))
      else $error("clear fault did not reach disabled");
   a_voltage_bit: assert property ( // R4
      STATE_WORD_OUT[4] == 1'b1)
      else $error("voltage enabled bit dropped");
   a_cal_power: assert property ( // R2
      ADC_CAL_IN && !fault_any
      |=> STATE_WORD_OUT[8] && !POWER_EN_OUT && (PWM_EN_OUT || q.state == ST_FAULT))
      else $error("calibration must switch without power");
   a_sync_hold: assert property ( // R18
      q.mode_act == `SDSM_MODE_SYNC_POS && !SYNC_IN |=> $stable(q.pos_ref))
      else $error("sync reference moved without sync");
   a_mode_reject: assert property ( // R17
      OBJ_WR_IN && OBJ_INDEX_IN == `SDSM_IDX_MODE_SEL && !mode_ok
      |=> OBJ_ERR_OUT && $stable(q.mode_sel))
      else $error("bad mode code accepted");
   a_ignore_cmd: assert property ( // R25
      q.state == ST_DIS && cmd != CMD_SHUTDOWN && !fault_any |=> q.state == ST_DIS)
      else $error("unmatched command changed state");

endmodule : sdsm_supervisor
`default_nettype wire

// [test/sdsm_host_model.sv]
`timescale 1ns/10ps
`default_nettype none
`include "sdsm_regs.svh"

module sdsm_host_model (
   // Clock and answers
   input wire logic clk_in,
   input wire logic [31:0] rdata_in,
   input wire logic ack_in,
   input wire logic err_in,
   // Requests
   output logic [15:0] index_out,
   output logic wr_out,
   output logic rd_out,
   output logic [31:0] wdata_out
);
   // No request pending at time zero
   initial begin
      index_out = 16'h0000;
      wr_out = 1'b0;
      rd_out = 1'b0;
      wdata_out = 32'h00000000;
   end

   // One-cycle request pulse, since a held strobe would be a second access
   task automatic access(input logic w, input logic [15:0] idx, input logic [31:0] d,
      output logic [31:0] q, output logic e);
      @(posedge clk_in);
      index_out <= idx;
      wr_out <= w;
      rd_out <= !w;
      wdata_out <= d;
      @(posedge clk_in);
      wr_out <= 1'b0;
      rd_out <= 1'b0;
      index_out <= ~idx; // Released lines never keep the old value
      wdata_out <= ~d;
      @(posedge clk_in);
      q = (ack_in === 1'b1) ? rdata_in : 32'hFFFFFFFF; // Missing answer spoils both
      e = (ack_in === 1'b1) ? err_in : 1'b1;
   endtask : access

   // Poll the state word, giving up after ten reads
   task automatic await_state(input logic [6:0] code, output logic ok);
      logic [31:0] q;
      logic e;
      ok = 1'b0;
      for (int i = 0; i < 10 && !ok; i++) begin
         access(1'b0, `SDSM_IDX_STATE_WORD, 32'h00000000, q, e);
         ok = (q[6:0] === code);
      end
   endtask : await_state

   // Power-up: shutdown, wait ready, enable operation, wait running
   task automatic start_motor(output logic ok);
      logic [31:0] q;
      logic e;
      logic r;
      access(1'b1, `SDSM_IDX_CMD_WORD, 32'h00000006, q, e);
      await_state(7'h11, r);
      access(1'b1, `SDSM_IDX_CMD_WORD, 32'h0000000F, q, e);
      await_state(7'h17, ok);
      ok = ok & r;
   endtask : start_motor
endmodule : sdsm_host_model
`default_nettype wire

// [test/tb.sv]
`timescale 1ns/10ps
`default_nettype none
`include "sdsm_regs.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_mismatch++; \
   $display("wrong value at %0t: %h expected %h", $time, (a), (b)); end end

module tb;
   localparam int S_INI = 0;
   localparam int S_DIS = 1;
   localparam int S_RDY = 2;
   localparam int S_SWN = 3;
   localparam int S_RUN = 4;
   localparam int S_FLT = 5;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic init_done = 1'b0;
   logic adc_cal = 1'b0;
   logic sync = 1'b0;
   logic [15:0] cause = 16'h0000;
   logic [31:0] pos_meas = 32'h3F800000;
   logic [31:0] vel_meas = 32'hC2C80000;
   logic [31:0] pos_dem = 32'h40490FDB;
   logic [31:0] vel_dem = 32'h42480000;
   logic [15:0] cur_meas = 16'h8001;
   logic [15:0] vbus = 16'hFEDC;
   logic [15:0] idx;
   logic wr;
   logic rd;
   logic [31:0] wdata;
   logic [31:0] rdata;
   logic ack;
   logic err;
   logic [15:0] sword;
   logic [7:0] mode;
   logic drv;
   logic pwm;
   logic pwr;
   logic [31:0] pref;
   logic [31:0] vref;
   logic signed [15:0] cref;
   logic [31:0] seed = 32'h363A1F00;
   logic [31:0] q;
   logic [31:0] r;
   logic [31:0] p0;
   logic e;
   logic ok;
   logic [15:0] last_cmd = 16'h0000;
   logic [7:0] exp_mode = 8'h00;
   logic [15:0] corner [15] = '{16'h0006, 16'h0007, 16'h000F, 16'h0007, 16'h0006,
      16'h000F, 16'h0000, 16'h000B, 16'h0006, 16'h0004, 16'h0006, 16'h0007, 16'h0005,
      16'h0087, 16'h0002};
   logic [7:0] modes [6] = '{8'h01, 8'h03, 8'h04, 8'h02, 8'h00, 8'h08};
   logic [15:0] bad [5] = '{16'h1234, `SDSM_IDX_STATE_WORD, `SDSM_IDX_MODE_ACT,
      `SDSM_IDX_VBUS, `SDSM_IDX_FAULT_CAUSE};
   logic [15:0] rb_idx [7] = '{`SDSM_IDX_POS_MEAS, `SDSM_IDX_VEL_MEAS, `SDSM_IDX_POS_DEMAND,
      `SDSM_IDX_VEL_DEMAND, `SDSM_IDX_CUR_MEAS, `SDSM_IDX_VBUS, `SDSM_IDX_VEL_SET};
   logic [31:0] rb_exp [7];
   int exp_s = S_INI;
   int n_mismatch = 0;
   int n_checks = 0;

   // Device and host
   sdsm_supervisor u_dut (.SYS_CLK_IN(clk), .RESETN_IN(rstn), .OBJ_INDEX_IN(idx),
      .OBJ_WR_IN(wr), .OBJ_RD_IN(rd), .OBJ_WDATA_IN(wdata), .OBJ_RDATA_OUT(rdata),
      .OBJ_ACK_OUT(ack), .OBJ_ERR_OUT(err), .INIT_DONE_IN(init_done),
      .FAULT_CAUSE_IN(cause), .ADC_CAL_IN(adc_cal), .SYNC_IN(sync),
      .POS_MEAS_IN(pos_meas), .VEL_MEAS_IN(vel_meas), .POS_DEMAND_IN(pos_dem),
      .VEL_DEMAND_IN(vel_dem), .CUR_MEAS_IN(cur_meas), .VBUS_MV_IN(vbus),
      .STATE_WORD_OUT(sword), .MODE_ACTIVE_OUT(mode), .DRIVE_EN_OUT(drv),
      .PWM_EN_OUT(pwm), .POWER_EN_OUT(pwr), .POS_REF_OUT(pref), .VEL_REF_OUT(vref),
      .CUR_REF_OUT(cref));
   sdsm_host_model u_host (.clk_in(clk), .rdata_in(rdata), .ack_in(ack), .err_in(err),
      .index_out(idx), .wr_out(wr), .rd_out(rd), .wdata_out(wdata));

   // 50 MHz clock
   always #10 clk = ~clk;

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   // Command applied as a level: clear first, then voltage, shutdown, run bit
   function automatic int next_st(input int s, input logic [15:0] c);
      if (c[7]) return (s == S_FLT) ? S_DIS : s;
      if (s == S_FLT || s == S_INI) return s;
      if (!c[1]) return S_DIS;
      if (!c[0]) return S_RDY;
      if (c[3]) return (s == S_RDY || s == S_SWN) ? S_RUN : s;
      return (s == S_RDY || s == S_RUN) ? S_SWN : s;
   endfunction : next_st

   function automatic logic [15:0] exp_word(input int s, input logic cal);
      logic [4:0] c;
      c = (s == S_DIS) ? 5'h10 : (s == S_RDY) ? 5'h01 : (s == S_SWN) ? 5'h03 :
         (s == S_RUN) ? 5'h07 : (s == S_FLT) ? 5'h08 : 5'h00;
      return {7'h00, cal, 1'b0, c[4], 1'b0, 1'b1, c[3:0]};
   endfunction : exp_word

   task automatic check_state(input int s);
      `CHK(sword, exp_word(s, 1'b0))
      `CHK({drv, pwm, pwr}, (s == S_SWN) ? 3'b100 : (s == S_RUN) ? 3'b111 : 3'b000)
      u_host.access(1'b0, `SDSM_IDX_STATE_WORD, 32'h00000000, q, e);
      `CHK(q, {16'h0000, exp_word(s, 1'b0)})
   endtask : check_state

   // Three edges cover the two-step enable from ready
   task automatic send_cmd(input logic [15:0] c);
      u_host.access(1'b1, `SDSM_IDX_CMD_WORD, {16'h0000, c}, q, e);
      `CHK(e, 1'b0)
      last_cmd = c;
      repeat (3) @(posedge clk);
      exp_s = next_st(next_st(exp_s, c), c);
      check_state(exp_s);
   endtask : send_cmd

   task automatic fault(input logic [15:0] c);
      cause <= c;
      repeat (3) @(posedge clk);
      check_state(S_FLT);
      u_host.access(1'b0, `SDSM_IDX_FAULT_CAUSE, 32'h00000000, q, e);
      `CHK(q, {16'h0000, c})
      cause <= 16'h0000;
      repeat (3) @(posedge clk);
      exp_s = next_st(S_FLT, last_cmd);
      check_state(exp_s);
   endtask : fault

   task automatic stop_test();
      $display("mismatches %0d, checks %0d", n_mismatch, n_checks);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : stop_test

   // Main sequence
   initial begin
      repeat (6) @(posedge clk);
      `CHK(sword, 16'h0010)
      rstn <= 1'b1;
      repeat (4) @(posedge clk);
      check_state(S_INI);
      init_done <= 1'b1;
      repeat (3) @(posedge clk);
      exp_s = S_DIS;
      check_state(exp_s);
      u_host.start_motor(ok);
      `CHK(ok, 1'b1)
      exp_s = S_RUN;
      adc_cal <= 1'b1;
      repeat (3) @(posedge clk);
      `CHK(sword, exp_word(S_RUN, 1'b1))
      `CHK({pwm, pwr}, 2'b10)
      adc_cal <= 1'b0;
      foreach (corner[i]) send_cmd(corner[i]);
      fault(16'h0200);
      send_cmd(16'h008F);
      for (int i = 0; i < 48; i++) begin
         r = rnd();
         pos_meas <= rnd();
         if (r[31:29] == 3'h0 && exp_s != S_FLT) fault(r[15:0] | 16'h0200);
         else send_cmd({r[15:8], r[7] & r[6] & r[5], r[6:0]});
      end
      // Setpoint follows directly outside synchronous mode
      p0 = rnd();
      u_host.access(1'b1, `SDSM_IDX_POS_SET, p0, q, e);
      repeat (2) @(posedge clk);
      `CHK(pref, p0)
      foreach (modes[i]) begin
         u_host.access(1'b1, `SDSM_IDX_MODE_SEL, {24'h000000, modes[i]}, q, e);
         `CHK(e, modes[i] == 8'h02)
         if (modes[i] != 8'h02) exp_mode = modes[i];
         u_host.access(1'b0, `SDSM_IDX_MODE_ACT, 32'h00000000, q, e);
         `CHK(q, {24'h000000, exp_mode})
         `CHK(mode, exp_mode)
      end
      r = rnd();
      u_host.access(1'b1, `SDSM_IDX_POS_SET, r, q, e);
      u_host.access(1'b1, `SDSM_IDX_VEL_SET, r, q, e);
      repeat (3) @(posedge clk);
      `CHK(pref, p0)
      `CHK(vref, r)
      sync <= 1'b1;
      @(posedge clk);
      sync <= 1'b0;
      repeat (2) @(posedge clk);
      `CHK(pref, r)
      foreach (bad[i]) begin
         u_host.access(1'b1, bad[i], 32'h0000FFFF, q, e);
         `CHK(e, 1'b1)
      end
      rb_exp = '{pos_meas, vel_meas, pos_dem, vel_dem, {{16{cur_meas[15]}}, cur_meas},
         {16'h0000, vbus}, r};
      foreach (rb_idx[i]) begin
         u_host.access(1'b0, rb_idx[i], 32'h00000000, q, e);
         `CHK(q, rb_exp[i])
      end
      u_host.access(1'b1, `SDSM_IDX_CUR_SET, 32'h00004000, q, e);
      repeat (2) @(posedge clk);
      `CHK(cref < 16'sh0200, 1'b1)
      stop_test();
   end

   // Watchdog well past the expected run length
   initial begin
      #(20 * 20000);
      n_mismatch++;
      stop_test();
   end
endmodule : tb
`default_nettype wire
